// *** logic/qoc_defines.svh ***
// offsets, field positions and reset values of the offset correction registers
`ifndef QOC_DEFINES_SVH
`define QOC_DEFINES_SVH
`define QOC_IDX_OFS_A 8'h08
`define QOC_IDX_OFS_B 8'h09
`define QOC_IDX_OFS_C 8'h0a
`define QOC_IDX_OFS_D 8'h0b
`define QOC_IDX_SYNC_CFG 8'h1e
`define QOC_OFS_MSB 12
`define QOC_PTR_MSB 15
`define QOC_PTR_LSB 13
`define QOC_RST_OFS_A 16'h0000
`define QOC_RST_OFS_B 16'h8000
`define QOC_RST_OFS_C 16'h0000
`define QOC_RST_OFS_D 16'h0000
`define QOC_RST_SYNC_CFG 16'h0003
`endif

// *** logic/qoc_pkg.sv ***
// types shared by the offset correction register bank
`default_nettype none
package qoc_pkg;
    typedef logic [12:0] qoc_offset_t;
    typedef logic [2:0] qoc_ptr_t;
    typedef logic [15:0] qoc_word_t;
    typedef logic [15:0] qoc_sample_t;
endpackage : qoc_pkg
`default_nettype wire

// *** logic/qoc_offset_add.sv ***
// one channel offset adder with staged-to-active load
`timescale 1ns/1ps
`default_nettype none
module qoc_offset_add
    import qoc_pkg::*;
(
    input wire logic core_clk_in, // clock
    input wire logic rst_in, // sync reset, active high
    input wire qoc_offset_t staged_in, // staged offset word
    input wire logic load_in, // sync pulse, takes staged word
    input wire qoc_sample_t sample_in, // sample in
    output qoc_offset_t active_out, // active offset
    output qoc_sample_t sample_out // corrected sample
);
    qoc_offset_t act_q, act_d;
    qoc_sample_t smp_q, smp_d;

    always_comb begin
        act_d = act_q;
        if (load_in) begin
            act_d = staged_in;
        end
        // two's complement offset sign-extended to sample width, wraps on overflow
        smp_d = 16'(sample_in + {{3{act_q[12]}}, act_q});
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            act_q <= 13'h0000;
            smp_q <= 16'h0000;
        end else begin
            act_q <= act_d;
            smp_q <= smp_d;
        end
    end

    assign active_out = act_q;
    assign sample_out = smp_q;
endmodule : qoc_offset_add
`default_nettype wire

// *** logic/qoc_regs.sv ***
// quad channel offset correction registers with AHB-Lite slave
// Operation
// - hold 13-bit channel A offset in low field of its register
// - hold 13-bit channel B offset in low field of its register
// - hold 13-bit channel C offset in low field of its register
// - hold 13-bit channel D offset in low field of its register
// - writing A register, sync enabled, loads A and B together; B write alone doesn't
// - writing C register, sync enabled, loads C and D together; D write alone doesn't
// - on FIFO sync, load 3-bit preset into read pointer; preset resets to 100
`timescale 1ns/1ps
`default_nettype none
`include "qoc_defines.svh"
module qoc_regs
    import qoc_pkg::*;
(
    input wire logic core_clk_in, // 50 MHz clock
    input wire logic rst_in, // sync reset, active high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic fifo_sync_in, // fifo sync event pulse, same clock
    output qoc_ptr_t read_ptr_out, // fifo read pointer
    input wire qoc_sample_t sample_a_in, // channel_a sample
    input wire qoc_sample_t sample_b_in, // channel_b sample
    input wire qoc_sample_t sample_c_in, // channel_c sample
    input wire qoc_sample_t sample_d_in, // channel_d sample
    output qoc_sample_t sample_a_out, // corrected channel_a
    output qoc_sample_t sample_b_out, // corrected channel_b
    output qoc_sample_t sample_c_out, // corrected channel_c
    output qoc_sample_t sample_d_out, // corrected channel_d
    output qoc_offset_t active_a_out, // active offset channel_a
    output qoc_offset_t active_b_out, // active offset channel_b
    output qoc_offset_t active_c_out, // active offset channel_c
    output qoc_offset_t active_d_out // active offset channel_d
);
    // staged register words
    qoc_word_t ofs_a_q, ofs_a_d;
    qoc_word_t ofs_b_q, ofs_b_d;
    qoc_word_t ofs_c_q, ofs_c_d;
    qoc_word_t ofs_d_q, ofs_d_d;
    qoc_word_t sync_cfg_q, sync_cfg_d;
    // bus address phase capture
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_idx_q, wr_idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    qoc_ptr_t rptr_q, rptr_d;
    logic sync_ab_q, sync_ab_d;
    logic sync_cd_q, sync_cd_d;
    logic addr_ok;
    logic [7:0] addr_idx;
    qoc_word_t wr_word;

    // register index from byte address; each register is one word
    function automatic logic [7:0] byte_to_idx(input logic [31:0] a);
        if (|a[31:10]) begin
            // beyond the map: index 0 holds no register, so no alias of a low word
            byte_to_idx = 8'h00;
        end else begin
            byte_to_idx = a[9:2];
        end
    endfunction : byte_to_idx

    function automatic qoc_word_t read_word(input logic [7:0] idx, input qoc_word_t a,
            input qoc_word_t b, input qoc_word_t c, input qoc_word_t d, input qoc_word_t s);
        case (idx)
            `QOC_IDX_OFS_A: read_word = a;
            `QOC_IDX_OFS_B: read_word = b;
            `QOC_IDX_OFS_C: read_word = c;
            `QOC_IDX_OFS_D: read_word = d;
            `QOC_IDX_SYNC_CFG: read_word = s;
            default: read_word = 16'h0000;
        endcase
    endfunction : read_word

    // stored form of a written word: reserved bits of each register stay zero
    function automatic qoc_word_t fold_word(input logic [7:0] idx, input logic [31:0] w);
        case (idx)
            `QOC_IDX_OFS_A: fold_word = {3'h0, w[`QOC_OFS_MSB:0]};
            `QOC_IDX_OFS_B: fold_word = w[15:0];
            `QOC_IDX_OFS_C: fold_word = {3'h0, w[`QOC_OFS_MSB:0]};
            `QOC_IDX_OFS_D: fold_word = {3'h0, w[`QOC_OFS_MSB:0]};
            `QOC_IDX_SYNC_CFG: fold_word = {14'h0000, w[1:0]};
            default: fold_word = 16'h0000;
        endcase
    endfunction : fold_word

    assign addr_ok = hsel && hready && htrans[1];
    assign addr_idx = byte_to_idx(haddr);
    assign wr_word = fold_word(wr_idx_q, hwdata);

    always_comb begin
        wr_pend_d = addr_ok && hwrite;
        wr_idx_d = addr_idx;
        hrdata_d = 32'h00000000;
        if (addr_ok && !hwrite) begin
            // a write in its data phase lands at this same edge, so pass its word on
            if (wr_pend_q && wr_idx_q == addr_idx) begin
                hrdata_d = {16'h0000, wr_word};
            end else begin
                hrdata_d = {16'h0000, read_word(addr_idx, ofs_a_q, ofs_b_q, ofs_c_q,
                    ofs_d_q, sync_cfg_q)};
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            hrdata_q <= hrdata_d;
        end
    end

    // channel_a/channel_b pair: staged words and the pulse that loads them together
    always_comb begin
        ofs_a_d = ofs_a_q;
        ofs_b_d = ofs_b_q;
        sync_ab_d = 1'b0;
        if (wr_pend_q && wr_idx_q == `QOC_IDX_OFS_A) begin
            ofs_a_d = wr_word;
            // only the first-channel write syncs, so a lone b write stays staged
            sync_ab_d = sync_cfg_q[0];
        end
        if (wr_pend_q && wr_idx_q == `QOC_IDX_OFS_B) begin
            ofs_b_d = wr_word;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ofs_a_q <= `QOC_RST_OFS_A;
            ofs_b_q <= `QOC_RST_OFS_B;
            sync_ab_q <= 1'b0;
        end else begin
            ofs_a_q <= ofs_a_d;
            ofs_b_q <= ofs_b_d;
            sync_ab_q <= sync_ab_d;
        end
    end

    // channel_c/channel_d pair, same scheme
    always_comb begin
        ofs_c_d = ofs_c_q;
        ofs_d_d = ofs_d_q;
        sync_cd_d = 1'b0;
        if (wr_pend_q && wr_idx_q == `QOC_IDX_OFS_C) begin
            ofs_c_d = wr_word;
            sync_cd_d = sync_cfg_q[1];
        end
        if (wr_pend_q && wr_idx_q == `QOC_IDX_OFS_D) begin
            ofs_d_d = wr_word;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ofs_c_q <= `QOC_RST_OFS_C;
            ofs_d_q <= `QOC_RST_OFS_D;
            sync_cd_q <= 1'b0;
        end else begin
            ofs_c_q <= ofs_c_d;
            ofs_d_q <= ofs_d_d;
            sync_cd_q <= sync_cd_d;
        end
    end

    // sync source enables, one bit per pair
    always_comb begin
        sync_cfg_d = sync_cfg_q;
        if (wr_pend_q && wr_idx_q == `QOC_IDX_SYNC_CFG) begin
            sync_cfg_d = wr_word;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sync_cfg_q <= `QOC_RST_SYNC_CFG;
        end else begin
            sync_cfg_q <= sync_cfg_d;
        end
    end

    // read pointer keeps its value between fifo sync events
    always_comb begin
        rptr_d = rptr_q;
        if (fifo_sync_in) begin
            rptr_d = ofs_b_q[`QOC_PTR_MSB:`QOC_PTR_LSB];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rptr_q <= 3'h0;
        end else begin
            rptr_q <= rptr_d;
        end
    end

    // zero wait states; okay always
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign read_ptr_out = rptr_q;

    // a pair loads from staged words on one pulse, so both change on the same edge
    qoc_offset_add u_add_a (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .staged_in(ofs_a_q[`QOC_OFS_MSB:0]),
        .load_in(sync_ab_q),
        .sample_in(sample_a_in),
        .active_out(active_a_out),
        .sample_out(sample_a_out)
    );
    qoc_offset_add u_add_b (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .staged_in(ofs_b_q[`QOC_OFS_MSB:0]),
        .load_in(sync_ab_q),
        .sample_in(sample_b_in),
        .active_out(active_b_out),
        .sample_out(sample_b_out)
    );
    qoc_offset_add u_add_c (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .staged_in(ofs_c_q[`QOC_OFS_MSB:0]),
        .load_in(sync_cd_q),
        .sample_in(sample_c_in),
        .active_out(active_c_out),
        .sample_out(sample_c_out)
    );
    qoc_offset_add u_add_d (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .staged_in(ofs_d_q[`QOC_OFS_MSB:0]),
        .load_in(sync_cd_q),
        .sample_in(sample_d_in),
        .active_out(active_d_out),
        .sample_out(sample_d_out)
    );
endmodule : qoc_regs
`default_nettype wire

// *** tb/qoc_regs_props.sv ***
// port assertions for the offset correction register bank
`timescale 1ns/1ps
`default_nettype none
`include "qoc_defines.svh"
module qoc_regs_props
    import qoc_pkg::*;
(
    input wire logic core_clk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic fifo_sync_in, // fifo sync
    input wire qoc_ptr_t read_ptr_out, // read pointer
    input wire qoc_sample_t sample_a_in, // sample a
    input wire qoc_sample_t sample_d_in, // sample d
    input wire qoc_sample_t sample_a_out, // corrected a
    input wire qoc_sample_t sample_d_out, // corrected d
    input wire qoc_offset_t active_a_out, // active a
    input wire qoc_offset_t active_b_out, // active b
    input wire qoc_offset_t active_c_out, // active c
    input wire qoc_offset_t active_d_out // active d
);
    wire logic tk = hsel && hready && htrans[1];
    wire logic wa = tk && hwrite && haddr == {22'h0, `QOC_IDX_OFS_A, 2'b00};
    wire logic wc = tk && hwrite && haddr == {22'h0, `QOC_IDX_OFS_C, 2'b00};
    wire qoc_sample_t ext_a = {{3{active_a_out[12]}}, active_a_out};
    wire qoc_sample_t ext_d = {{3{active_d_out[12]}}, active_d_out};
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // pair moves only three edges after an address phase to its first register
    ab_sync_a: assert property ($changed(active_a_out) || $changed(active_b_out)
        |-> $past(wa, 3))
        else $error("ab offsets moved without a write to a");
    cd_sync_a: assert property ($changed(active_c_out) || $changed(active_d_out)
        |-> $past(wc, 3))
        else $error("cd offsets moved without a write to c");
    ptr_hold_a: assert property (!fifo_sync_in |=> $stable(read_ptr_out))
        else $error("read pointer moved without sync");
    rd_idle_a: assert property (!(tk && !hwrite) |=> hrdata == 32'h0)
        else $error("read data not zero outside read");
    rd_upper_a: assert property (hrdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    sum_cha_a: assert property (1'b1 |=> sample_a_out
        == $past(sample_a_in) + $past(ext_a))
        else $error("channel a sum wrong");
    sum_chd_a: assert property (1'b1 |=> sample_d_out
        == $past(sample_d_in) + $past(ext_d))
        else $error("channel d sum wrong");
endmodule : qoc_regs_props
bind qoc_regs qoc_regs_props u_props (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fifo_sync_in(fifo_sync_in),
    .read_ptr_out(read_ptr_out), .sample_a_in(sample_a_in), .sample_d_in(sample_d_in),
    .sample_a_out(sample_a_out), .sample_d_out(sample_d_out), .active_a_out(active_a_out),
    .active_b_out(active_b_out), .active_c_out(active_c_out), .active_d_out(active_d_out));
`default_nettype wire

// *** tb/qoc_regs_bench.sv ***
// self-checking bench for the offset correction register bank
`timescale 1ns/1ps
`default_nettype none
`include "qoc_defines.svh"
module qoc_regs_bench;
    import qoc_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic fifo_sync_in = 1'b0;
    qoc_sample_t smp_in [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
    qoc_sample_t smp_out [4];
    qoc_offset_t act [4];
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    qoc_ptr_t read_ptr_out;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] rd;
    qoc_regs dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fifo_sync_in(fifo_sync_in),
        .read_ptr_out(read_ptr_out), .sample_a_in(smp_in[0]), .sample_b_in(smp_in[1]),
        .sample_c_in(smp_in[2]), .sample_d_in(smp_in[3]), .sample_a_out(smp_out[0]),
        .sample_b_out(smp_out[1]), .sample_c_out(smp_out[2]), .sample_d_out(smp_out[3]),
        .active_a_out(act[0]), .active_b_out(act[1]), .active_c_out(act[2]),
        .active_d_out(act[3]));
    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // hready is the slave's own hreadyout, so the waits end only on its answer
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge core_clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {16'h0, wd};
        do @(posedge core_clk_in); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic t_reset;
        logic [15:0] rv [4] = '{`QOC_RST_OFS_A, `QOC_RST_OFS_B, `QOC_RST_OFS_C, `QOC_RST_OFS_D};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 8'h08 + 8'(i), 16'h0);
            chk("reset word", {16'h0, rv[i]}, rd);
        end
        xfer(1'b0, 8'h3f, 16'h0);
        chk("unmapped read", 32'h0, rd);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fifo(input qoc_ptr_t exp);
        fifo_sync_in <= 1'b1;
        @(posedge core_clk_in);
        fifo_sync_in <= 1'b0;
        @(posedge core_clk_in);
        chk("read pointer", {29'h0, exp}, {29'h0, read_ptr_out});
        $display("fifo test done");
    endtask : t_fifo
    task automatic t_pair(input int k);
        logic [7:0] lo;
        lo = 8'h08 + 8'(2 * k);
        xfer(1'b1, lo + 8'h01, 16'hfabc);
        xfer(1'b0, lo + 8'h01, 16'h0);
        chk("second word", k ? 32'h1abc : 32'hfabc, rd);
        chk("second alone", 32'h0, {19'h0, act[2 * k + 1]});
        xfer(1'b1, lo, 16'hff00);
        xfer(1'b0, lo, 16'h0);
        chk("first word", 32'h1f00, rd);
        chk("first active", 32'h1f00, {19'h0, act[2 * k]});
        chk("second active", 32'h1abc, {19'h0, act[2 * k + 1]});
        $display("pair test done");
    endtask : t_pair
    task automatic t_nosync;
        xfer(1'b1, `QOC_IDX_SYNC_CFG, 16'h0000);
        xfer(1'b1, `QOC_IDX_OFS_A, 16'h0005);
        repeat (3) @(posedge core_clk_in);
        chk("sync off active", 32'h1f00, {19'h0, act[0]});
        xfer(1'b1, `QOC_IDX_SYNC_CFG, 16'h0003);
        xfer(1'b1, `QOC_IDX_OFS_A, 16'h0005);
        repeat (2) @(posedge core_clk_in);
        chk("sync on active", 32'h0005, {19'h0, act[0]});
        $display("sync enable test done");
    endtask : t_nosync
    task automatic t_sample;
        // negative offsets wrap the sum rather than saturate
        logic [15:0] ev [4] = '{16'h0128, 16'hfbdf, 16'h0023, 16'hfbdf};
        for (int i = 0; i < 4; i++) begin
            smp_in[i] <= 16'h0123;
        end
        repeat (2) @(posedge core_clk_in);
        for (int i = 0; i < 4; i++) begin
            chk("sample out", {16'h0, ev[i]}, {16'h0, smp_out[i]});
        end
        $display("sample test done");
    endtask : t_sample
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (3000) @(posedge core_clk_in);
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        t_reset();
        t_fifo(3'b100);
        t_pair(0);
        t_pair(1);
        t_nosync();
        t_fifo(3'b111);
        t_sample();
        stop_test();
    end
endmodule : qoc_regs_bench
`default_nettype wire
